// ===== pkg/uft_pkg.sv
// Constants, field layout and carrier types of the frame transmitter.
// Assumes an APB register bus with 32-bit data and a 12-bit byte address.
package uft_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int BAUD_W = 12;
   localparam int CHAR_W = 9;
   localparam int CNT_W = 4;

   localparam logic [ADDR_W-1:0] ADDR_DATA = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_CSA = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_CSB = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_CSC = 12'h00c;
   localparam logic [ADDR_W-1:0] ADDR_BAUD = 12'h010;

   localparam int CSA_BUSY = 0;
   localparam int CSA_DBL = 1;
   localparam int CSA_EMPTY = 5;
   localparam int CSA_TXC = 6;
   localparam int CSB_NINTH = 0;
   localparam int CSB_TX_ENABLE_BIT = 3;
   localparam int CSC_SIZE_LO = 0;
   localparam int CSC_PAR_LO = 3;
   localparam int CSC_STOP = 5;
   localparam int CSC_SYNC = 6;
   localparam int CSC_POL = 7;
   localparam int CSC_SLAVE = 8;
   localparam int PAR_EN_BIT = 1;
   localparam int PAR_ODD_BIT = 0;

   localparam logic [2:0] SIZE_5 = 3'h0;
   localparam logic [2:0] SIZE_6 = 3'h1;
   localparam logic [2:0] SIZE_7 = 3'h2;
   localparam logic [2:0] SIZE_8 = 3'h3;
   localparam logic [2:0] SIZE_9 = 3'h7;
   localparam logic [1:0] PAR_RST = 2'h0;
   localparam logic [BAUD_W-1:0] BAUD_RST = 12'h000;
   localparam logic [CNT_W-1:0] PRESC_NORMAL = 4'hf;
   localparam logic [CNT_W-1:0] PRESC_DOUBLE = 4'h7;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

   typedef struct packed {
      logic stop2;
      logic [1:0] parity;
      logic [2:0] size;
   } uft_fmt_s;

   typedef struct packed {
      logic sync;
      logic slave;
      logic pol;
      logic dbl;
   } uft_clk_cfg_s;

   // Data bits per character; reserved codes fall back to eight
   function automatic logic [CNT_W-1:0] uft_char_bits(input logic [2:0] size);
      logic [CNT_W-1:0] n;
      n = 4'h8;
      if (size == SIZE_5) n = 4'h5;
      else if (size == SIZE_6) n = 4'h6;
      else if (size == SIZE_7) n = 4'h7;
      else if (size == SIZE_9) n = 4'h9;
      return n;
   endfunction

   // Keeps only the bits that belong to the character
   function automatic logic [CHAR_W-1:0] uft_char_mask(input logic [2:0] size);
      logic [CHAR_W-1:0] m;
      int i;
      m = '0;
      for (i = 0; i < CHAR_W; i++)
      begin
         m[i] = (i < int'(uft_char_bits(size)));
      end
      return m;
   endfunction
endpackage

// ===== sim/testbench.sv
// Self-checking bench for the frame transmitter.
// Assumes uft_pkg compiled first; far side is uft_rx_model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
   import uft_pkg::*;
   logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata;
   logic pready, pslverr, so, soe, xi, xo, xoe, got, mpb, msp;
   logic [7:0] bclk = 8'h10;
   logic [3:0] mnb = 4'h8;
   logic mpar = 0;
   logic [8:0] mdat;
   time mt;
   logic [8:0] qd[$];
   logic qp[$];
   logic qs[$];
   time qt[$];
   int err_count = 0, num_checks = 0;
   logic [11:0] ra[6] = '{ADDR_DATA, ADDR_CSA, ADDR_CSB, ADDR_CSC, ADDR_BAUD, 12'h014};
   logic [31:0] rv[6] = '{32'h0, 32'h20, 32'h0, 32'h3, 32'h0, 32'h0};
   logic [2:0] szs[5] = '{SIZE_5, SIZE_6, SIZE_7, SIZE_8, SIZE_9};
   logic [3:0] nbs[5] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
   logic [1:0] pms[3] = '{2'h0, 2'h2, 2'h3};
   always #4 clk = ~clk;
   uft_tx_top uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_out_pin_o(so), .serial_out_pin_oe(soe), .transfer_clock_pin_i(xi),
      .transfer_clock_pin_o(xo), .transfer_clock_pin_oe(xoe));
   uft_rx_model u_far (.clk(clk), .line(so), .oe(soe), .bit_clks(bclk), .nbits(mnb),
      .par_en(mpar), .xck(xi), .got(got), .data(mdat), .par_bit(mpb), .stop_ok(msp), .start_t(mt));
   always @(posedge got)
   begin
      qd.push_back(mdat);
      qp.push_back(mpb);
      qs.push_back(msp);
      qt.push_back(mt);
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 0;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      xfer(1, a, d, r, e);
   endtask
   task automatic poll(input int b);
      logic [31:0] r;
      logic e;
      int n;
      n = 0;
      do xfer(0, ADDR_CSA, 0, r, e); while (r[b] !== 1'b1 && ++n < 3000);
   endtask
   task automatic send(input logic [7:0] d);
      poll(CSA_EMPTY);
      wr(ADDR_DATA, {24'hffffff, d});
   endtask
   task automatic wait_done(input logic dbl);
      poll(CSA_TXC);
      wr(ADDR_CSA, 32'h40 | {30'h0, dbl, 1'b0});
   endtask
   task automatic flush;
      qd.delete();
      qp.delete();
      qs.delete();
      qt.delete();
   endtask
   task conclude;
      $display("counts: %0d checks, %0d mismatches", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge clk);
      err_count++;
      conclude;
   end
   initial
   begin
      logic [31:0] r;
      logic e, gp, gs, pv;
      logic [8:0] d, ex, gd;
      int k, tog;
      repeat (2) @(posedge clk);
      nrst <= 1;
      for (k = 0; k < 6; k++)
      begin
         xfer(0, ra[k], 0, r, e);
         `CHK(r, rv[k]);
         `CHK(e, k == 5);
      end
      $display("done: reset values");
      wr(ADDR_BAUD, 0);
      wr(ADDR_CSB, 32'h8);
      k = 0;
      for (int s = 0; s < 5; s++)
         for (int p = 0; p < 3; p++)
            for (int t = 0; t < 2; t++)
            begin
               d = 9'h1a5 ^ 9'(k * 37);
               k++;
               mnb <= nbs[s];
               mpar <= pms[p][1];
               wr(ADDR_CSC, {26'h0, t[0], pms[p], szs[s]});
               wr(ADDR_CSB, {28'h0, 1'b1, 2'h0, d[8]});
               send(d[7:0]);
               wait_done(0);
               ex = d & ((9'h1 << nbs[s]) - 9'h1);
               pv = ^ex ^ pms[p][0];
               gd = qd.pop_front();
               gp = qp.pop_front();
               gs = qs.pop_front();
               `CHK(gd, ex);
               if (pms[p][1]) `CHK(gp, pv);
               `CHK(gs, 1'b1);
            end
      flush;
      $display("done: frame formats");
      mnb <= 4'h8;
      mpar <= 0;
      wr(ADDR_CSC, 32'h3);
      wr(ADDR_CSB, 32'h8);
      send(8'h5a);
      send(8'hc3);
      xfer(0, ADDR_CSA, 0, r, e);
      `CHK(r, 32'h1);
      wait_done(0);
      `CHK(qd[0], 9'h05a);
      `CHK(qd[1], 9'h0c3);
      `CHK((qt[1] - qt[0]) / 8, time'(160));
      xfer(0, ADDR_CSA, 0, r, e);
      `CHK(r, 32'h20);
      flush;
      $display("done: back to back");
      for (int m = 0; m < 2; m++)
      begin
         bclk <= m ? 8'h08 : 8'h20;
         wr(ADDR_BAUD, m ? 32'h0 : 32'h1);
         wr(ADDR_CSA, m ? 32'h2 : 32'h0);
         send(8'h3c + 8'(m));
         wait_done(m[0]);
         gd = qd.pop_front();
         `CHK(gd, 9'h03c + 9'(m));
      end
      wr(ADDR_CSA, 0);
      bclk <= 8'h10;
      flush;
      $display("done: bit rates");
      send(8'h96);
      wr(ADDR_CSB, 32'h0);
      k = 0;
      while (soe === 1'b1 && k < 400)
      begin
         @(posedge clk);
         k++;
      end
      `CHK(soe, 1'b0);
      `CHK(qd[0], 9'h096);
      flush;
      wr(ADDR_CSB, 32'h8);
      wr(ADDR_CSA, 32'h40);
      $display("done: disable");
      wr(ADDR_BAUD, 1);
      wr(ADDR_CSC, 32'h43);
      xfer(0, ADDR_CSC, 0, r, e);
      `CHK(r, 32'h43);
      repeat (4) @(posedge clk);
      `CHK(xoe, 1'b1);
      tog = 0;
      gp = xo;
      repeat (40)
      begin
         @(posedge clk);
         if (xo !== gp) tog++;
         gp = xo;
      end
      `CHK(tog, 20);
      wr(ADDR_CSC, 32'h3);
      wr(ADDR_BAUD, 0);
      repeat (4) @(posedge clk);
      `CHK(xoe, 1'b0);
      $display("done: sync clock");
      conclude;
   end
endmodule
`default_nettype wire

// ===== sim/uft_rx_model.sv
// Remote serial receiver on the transmit line.
// Assumes bit time and character layout are set by the bench.
`timescale 1ns/1ps
`default_nettype none
module uft_rx_model (
   input wire logic clk,
   input wire logic line,
   input wire logic oe,
   input wire logic [7:0] bit_clks,
   input wire logic [3:0] nbits,
   input wire logic par_en,
   output logic xck,
   output logic got,
   output logic [8:0] data,
   output logic par_bit,
   output logic stop_ok,
   output time start_t
);
   logic st;
   // Slave clock unused: stands still
   assign xck = 1'b0;
   initial
   begin
      got = 1'b0;
      forever
      begin
         @(negedge line);
         if (oe === 1'b1)
         begin
            start_t = $time;
            repeat (bit_clks / 2) @(posedge clk);
            st = !line;
            data = '0;
            for (int i = 0; i < nbits; i++)
            begin
               repeat (bit_clks) @(posedge clk);
               data[i] = line;
            end
            if (par_en)
            begin
               repeat (bit_clks) @(posedge clk);
               par_bit = line;
            end
            repeat (bit_clks) @(posedge clk);
            stop_ok = line && st;
            got = 1'b1;
            @(posedge clk);
            got = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/uft_tx_monitor.sv
// Checker on the transmitter top ports.
// Assumes APB writes take effect at the access edge with pready high.
`timescale 1ns/1ps
`default_nettype none
module uft_tx_monitor
   import uft_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [uft_pkg::ADDR_W-1:0] paddr,
   input wire logic [uft_pkg::DATA_W-1:0] pwdata,
   input wire logic [uft_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_out_pin_o,
   input wire logic serial_out_pin_oe,
   input wire logic transfer_clock_pin_i,
   input wire logic transfer_clock_pin_o,
   input wire logic transfer_clock_pin_oe
);
   import uft_pkg::*;
   logic tx_enable_bit_sh;
   logic [8:0] csc_sh;
   logic wr_acc;
   logic sync_m;
   assign wr_acc = psel && penable && pready && pwrite;
   assign sync_m = csc_sh[CSC_SYNC] && !csc_sh[CSC_SLAVE];
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst) tx_enable_bit_sh <= 1'b0;
      else if (wr_acc && paddr == ADDR_CSB) tx_enable_bit_sh <= pwdata[CSB_TX_ENABLE_BIT];
   end
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst) csc_sh <= 9'h003;
      else if (wr_acc && paddr == ADDR_CSC) csc_sh <= pwdata[8:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      pready ##1 !pready;
   endsequence
   a_ready_answer: assert property (setup_s |=> answer_s)
      else $error("pready not one pulse after setup");
   a_unmapped_err: assert property (setup_s and (paddr > ADDR_BAUD) |=> pready && pslverr)
      else $error("no error on unmapped address");
   a_idle_high: assert property (!serial_out_pin_oe |-> serial_out_pin_o)
      else $error("released line not high");
   a_enable_owns: assert property ($rose(tx_enable_bit_sh) |-> ##[0:3] serial_out_pin_oe)
      else $error("serial pin not taken on enable");
   a_start_hold: assert property ($fell(serial_out_pin_o) && !sync_m |-> !serial_out_pin_o [*8])
      else $error("low bit shorter than a bit time");
   a_release_done: assert property ($fell(serial_out_pin_oe) |-> !tx_enable_bit_sh && $past(serial_out_pin_o, 8))
      else $error("serial pin released mid frame");
   a_clock_driven: assert property ($rose(sync_m) |-> ##[0:3] transfer_clock_pin_oe)
      else $error("transfer clock pin not taken");
   a_clock_quiet: assert property (!sync_m [*3] |-> !transfer_clock_pin_oe)
      else $error("transfer clock driven outside master mode");
endmodule
bind uft_tx_top uft_tx_monitor u_mon (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe(serial_out_pin_oe),
   .transfer_clock_pin_i(transfer_clock_pin_i), .transfer_clock_pin_o(transfer_clock_pin_o),
   .transfer_clock_pin_oe(transfer_clock_pin_oe));
`default_nettype wire

// ===== verilog/uft_baud_gen.sv
// Bit-rate tick generator: divisor down-counter, async prescaler,
// master clock output and slave clock edge detect.
// Assumes the slave clock input is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module uft_baud_gen
   import uft_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [uft_pkg::BAUD_W-1:0] divisor,
   input wire logic reload,
   input wire uft_pkg::uft_clk_cfg_s cfg,
   input wire logic xck_sync,
   output logic tick,
   output logic xck_out
);
   logic [BAUD_W-1:0] cnt_reg;
   logic [CNT_W-1:0] presc_reg;
   logic [CNT_W-1:0] limit;
   logic xck_prev_reg;
   logic bg_pulse;
   logic master;

   assign bg_pulse = (cnt_reg == BAUD_RST);
   assign limit = cfg.dbl ? PRESC_DOUBLE : PRESC_NORMAL;
   assign master = cfg.sync & ~cfg.slave;

   // Divisor reloads at zero or when software writes it
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         cnt_reg <= BAUD_RST;
      else if (reload || bg_pulse)
         cnt_reg <= divisor;
      else
         cnt_reg <= cnt_reg - 1'b1;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         presc_reg <= '0;
      else if (reload)
         presc_reg <= '0;
      else if (bg_pulse)
         presc_reg <= (presc_reg >= limit) ? '0 : presc_reg + 1'b1;
   end

   // Master clock toggles per divisor pulse, idles at polarity level
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         xck_out <= 1'b0;
      else if (!master)
         xck_out <= cfg.pol;
      else if (bg_pulse)
         xck_out <= ~xck_out;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         xck_prev_reg <= 1'b0;
      else
         xck_prev_reg <= xck_sync;
   end

   // Tick on the data-change edge in sync modes
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         tick <= 1'b0;
      else if (cfg.sync && cfg.slave)
         tick <= (xck_sync != xck_prev_reg) && (xck_sync == ~cfg.pol);
      else if (master)
         tick <= bg_pulse && (xck_out == cfg.pol);
      else
         tick <= bg_pulse && (presc_reg >= limit);
   end
endmodule
`default_nettype wire

// ===== verilog/uft_sync2.sv
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
`default_nettype none
module uft_sync2 (
   input wire logic clk,
   input wire logic nrst,
   input wire logic d,
   output logic q
);
   logic meta_reg;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_reg <= 1'b0;
         q <= 1'b0;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/uft_tx_top.sv
// Serial frame transmitter with APB registers, one transmit buffer
// and a frame shift register.
// Assumes an APB3 master on clk; link pins are outside the clock domain.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module uft_tx_top
   import uft_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [uft_pkg::ADDR_W-1:0] paddr,
   input wire logic [uft_pkg::DATA_W-1:0] pwdata,
   output logic [uft_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic serial_out_pin_o,
   output logic serial_out_pin_oe,
   input wire logic transfer_clock_pin_i,
   output logic transfer_clock_pin_o,
   output logic transfer_clock_pin_oe
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ARMED,
      ST_START,
      ST_DATA,
      ST_PARITY,
      ST_STOP1,
      ST_STOP2
   } uft_state_e;

   uft_state_e state_reg;
   uft_fmt_s fmt_reg;
   uft_clk_cfg_s clk_cfg_reg;
   logic [BAUD_W-1:0] baud_divisor_reg;
   logic tx_enable_bit_reg;
   logic ninth_tx_bit_reg;
   logic tx_complete_flag_reg;
   logic buf_full_reg;
   logic [CHAR_W-1:0] buf_reg;
   logic [CHAR_W-1:0] shift_reg;
   logic par_reg;
   logic [CNT_W-1:0] bit_cnt_reg;
   logic own_reg;
   logic xck_oe_reg;
   logic xck_sync;
   logic tick;
   logic xck_gen;
   logic wr_en;
   logic wr_data;
   logic wr_csa;
   logic wr_csb;
   logic wr_csc;
   logic wr_baud;
   logic frame_last;
   logic frame_end;
   logic load_now;
   logic txc_set;
   logic [CNT_W-1:0] nbits;
   logic par_en;

   // APB access phase completes at the edge where pready is high
   assign wr_en = psel && penable && pready && pwrite;
   assign wr_data = wr_en && (paddr == ADDR_DATA);
   assign wr_csa = wr_en && (paddr == ADDR_CSA);
   assign wr_csb = wr_en && (paddr == ADDR_CSB);
   assign wr_csc = wr_en && (paddr == ADDR_CSC);
   assign wr_baud = wr_en && (paddr == ADDR_BAUD);

   assign nbits = uft_char_bits(fmt_reg.size);
   assign par_en = fmt_reg.parity[PAR_EN_BIT];
   assign frame_last = (state_reg == ST_STOP2)
      || ((state_reg == ST_STOP1) && !fmt_reg.stop2);
   assign frame_end = tick && frame_last;
   assign load_now = buf_full_reg && own_reg
      && ((state_reg == ST_IDLE) || frame_end);
   assign txc_set = frame_end && !load_now;

   uft_sync2 u_xck_sync (
      .clk(clk),
      .nrst(nrst),
      .d(transfer_clock_pin_i),
      .q(xck_sync)
   );

   uft_baud_gen u_baud (
      .clk(clk),
      .nrst(nrst),
      .divisor(baud_divisor_reg),
      .reload(wr_baud),
      .cfg(clk_cfg_reg),
      .xck_sync(xck_sync),
      .tick(tick),
      .xck_out(xck_gen)
   );

   // No wait state: ready in the first access cycle
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         pready <= 1'b0;
      else
         pready <= psel && !penable;
   end

   // Read data and error are captured in the setup cycle
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         prdata <= '0;
         pslverr <= 1'b0;
      end
      else if (psel && !penable)
      begin
         prdata <= '0;
         pslverr <= 1'b0;
         if (paddr == ADDR_DATA)
            prdata <= '0;
         else if (paddr == ADDR_CSA)
         begin
            prdata[CSA_BUSY] <= (state_reg != ST_IDLE);
            prdata[CSA_DBL] <= clk_cfg_reg.dbl;
            prdata[CSA_EMPTY] <= !buf_full_reg;
            prdata[CSA_TXC] <= tx_complete_flag_reg;
         end
         else if (paddr == ADDR_CSB)
         begin
            prdata[CSB_NINTH] <= ninth_tx_bit_reg;
            prdata[CSB_TX_ENABLE_BIT] <= tx_enable_bit_reg;
         end
         else if (paddr == ADDR_CSC)
         begin
            prdata[CSC_SIZE_LO +: 3] <= fmt_reg.size;
            prdata[CSC_PAR_LO +: 2] <= fmt_reg.parity;
            prdata[CSC_STOP] <= fmt_reg.stop2;
            prdata[CSC_SYNC] <= clk_cfg_reg.sync;
            prdata[CSC_POL] <= clk_cfg_reg.pol;
            prdata[CSC_SLAVE] <= clk_cfg_reg.slave;
         end
         else if (paddr == ADDR_BAUD)
            prdata[BAUD_W-1:0] <= baud_divisor_reg;
         else
            pslverr <= 1'b1;
      end
      else
         pslverr <= 1'b0;
   end

   // Frame format and clock mode fields
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fmt_reg.size <= SIZE_8;
         fmt_reg.parity <= PAR_RST;
         fmt_reg.stop2 <= 1'b0;
         clk_cfg_reg.sync <= 1'b0;
         clk_cfg_reg.pol <= 1'b0;
         clk_cfg_reg.slave <= 1'b0;
      end
      else if (wr_csc)
      begin
         fmt_reg.size <= pwdata[CSC_SIZE_LO +: 3];
         fmt_reg.parity <= pwdata[CSC_PAR_LO +: 2];
         fmt_reg.stop2 <= pwdata[CSC_STOP];
         clk_cfg_reg.sync <= pwdata[CSC_SYNC];
         clk_cfg_reg.pol <= pwdata[CSC_POL];
         clk_cfg_reg.slave <= pwdata[CSC_SLAVE];
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         clk_cfg_reg.dbl <= 1'b0;
      else if (wr_csa)
         clk_cfg_reg.dbl <= pwdata[CSA_DBL];
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tx_enable_bit_reg <= 1'b0;
         ninth_tx_bit_reg <= 1'b0;
      end
      else if (wr_csb)
      begin
         tx_enable_bit_reg <= pwdata[CSB_TX_ENABLE_BIT];
         ninth_tx_bit_reg <= pwdata[CSB_NINTH];
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         baud_divisor_reg <= BAUD_RST;
      else if (wr_baud)
         baud_divisor_reg <= pwdata[BAUD_W-1:0];
   end

   // Transmit complete: set wins over a write-one clear
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         tx_complete_flag_reg <= 1'b0;
      else if (txc_set)
         tx_complete_flag_reg <= 1'b1;
      else if (wr_csa && pwdata[CSA_TXC])
         tx_complete_flag_reg <= 1'b0;
   end

   // Transmit buffer: a write fills it, a move to the shifter empties it
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         buf_full_reg <= 1'b0;
         buf_reg <= '0;
      end
      else if (wr_data)
      begin
         buf_full_reg <= 1'b1;
         buf_reg <= {ninth_tx_bit_reg, pwdata[7:0]}
            & uft_char_mask(fmt_reg.size);
      end
      else if (load_now)
         buf_full_reg <= 1'b0;
   end

   // Pin ownership lasts until shifter and buffer are drained
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         own_reg <= 1'b0;
      else if (tx_enable_bit_reg)
         own_reg <= 1'b1;
      else if ((state_reg == ST_IDLE) && !buf_full_reg)
         own_reg <= 1'b0;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         serial_out_pin_oe <= 1'b0;
      else
         serial_out_pin_oe <= own_reg;
   end

   // Master drives the transfer clock; slave listens on it
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         xck_oe_reg <= 1'b0;
         transfer_clock_pin_o <= 1'b0;
      end
      else
      begin
         xck_oe_reg <= clk_cfg_reg.sync && !clk_cfg_reg.slave && own_reg;
         transfer_clock_pin_o <= xck_gen;
      end
   end

   assign transfer_clock_pin_oe = xck_oe_reg;

   // Frame sequencer; every bit lasts one rate tick
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg <= ST_IDLE;
         shift_reg <= '0;
         par_reg <= 1'b0;
         bit_cnt_reg <= '0;
         serial_out_pin_o <= 1'b1;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               serial_out_pin_o <= 1'b1;
               if (load_now)
               begin
                  shift_reg <= buf_reg;
                  par_reg <= (^buf_reg) ^ fmt_reg.parity[PAR_ODD_BIT];
                  state_reg <= ST_ARMED;
               end
            end
            ST_ARMED:
               if (tick)
               begin
                  serial_out_pin_o <= 1'b0;
                  state_reg <= ST_START;
               end
            ST_START:
               if (tick)
               begin
                  serial_out_pin_o <= shift_reg[0];
                  shift_reg <= {1'b0, shift_reg[CHAR_W-1:1]};
                  bit_cnt_reg <= CNT_ONE;
                  state_reg <= ST_DATA;
               end
            ST_DATA:
               if (tick)
               begin
                  if (bit_cnt_reg >= nbits)
                  begin
                     if (par_en)
                     begin
                        serial_out_pin_o <= par_reg;
                        state_reg <= ST_PARITY;
                     end
                     else
                     begin
                        serial_out_pin_o <= 1'b1;
                        state_reg <= ST_STOP1;
                     end
                  end
                  else
                  begin
                     serial_out_pin_o <= shift_reg[0];
                     shift_reg <= {1'b0, shift_reg[CHAR_W-1:1]};
                     bit_cnt_reg <= bit_cnt_reg + 1'b1;
                  end
               end
            ST_PARITY:
               if (tick)
               begin
                  serial_out_pin_o <= 1'b1;
                  state_reg <= ST_STOP1;
               end
            ST_STOP1:
               // A far receiver judges framing on this bit alone
               if (tick && fmt_reg.stop2)
                  state_reg <= ST_STOP2;
            ST_STOP2:
               state_reg <= state_reg;
            default:
               state_reg <= ST_IDLE;
         endcase
         if (frame_end)
         begin
            if (load_now)
            begin
               shift_reg <= buf_reg;
               par_reg <= (^buf_reg) ^ fmt_reg.parity[PAR_ODD_BIT];
               serial_out_pin_o <= 1'b0;
               state_reg <= ST_START;
            end
            else
            begin
               serial_out_pin_o <= 1'b1;
               state_reg <= ST_IDLE;
            end
         end
      end
   end
endmodule
`default_nettype wire
